/* File: hdl/timer_irq_defs.svh */
`ifndef TIMER_IRQ_DEFS_SVH
`define TIMER_IRQ_DEFS_SVH

// ==========================================================================
// channel count
`define NUM_CH          6
`define CH_W            3

// ==========================================================================
// register map, byte addresses inside the slave window
`define ADDR_W          8
`define EN_BASE         8'h00
`define STAT_BASE       8'h20
`define REG_STRIDE      8'h04
`define WORD_ALIGN_MASK 8'h03

// ==========================================================================
// enable register fields
`define BIT_TRIG        7
`define BIT_RSV         6
`define BIT_UDF         5
`define BIT_OVF         4
`define BIT_MD          3
`define BIT_MC          2
`define BIT_MB          1
`define BIT_MA          0
`define MATCH_A_IDX     0
`define MATCH_B_IDX     1
`define MATCH_C_IDX     2
`define MATCH_D_IDX     3

// writable bits: channels with compare c/d, and channels with underflow
`define MASK_CD_CH      8'h9F
`define MASK_UDF_CH     8'hB3
`define RSV_ONES        8'h40
`define EN_RESET        8'h00

// ==========================================================================
// status register fields
`define FLAG_W          6
`define FLAG_RESET      6'h00
`define STAT_DIR_BIT    7
`define RDATA_PAD       24'h000000
`define BYTE_W          8

// ==========================================================================
// ahb encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY      1'b0

`endif

/* File: hdl/timer_irq_pkg.sv */
`include "timer_irq_defs.svh"

package timer_irq_pkg;

    // ======================================================================
    // bus slave phase
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WRITE = 3'b010,
        ST_READ  = 3'b100
    } bus_phase_type;

    // ======================================================================
    // carriers
    typedef struct packed {
        logic       overflow;
        logic       underflow;
        logic [3:0] match;
    } channel_event_type;

    typedef struct packed {
        logic underflow_irq_request;
        logic overflow_irq_request;
        logic match_d_irq_request;
        logic match_c_irq_request;
        logic match_b_irq_request;
        logic match_a_irq_request;
    } channel_request_type;

    typedef struct packed {
        logic              hit_enable;
        logic              hit_status;
        logic [`CH_W-1:0]  ch;
    } addr_decode_type;

    typedef struct packed {
        bus_phase_type                          phase;
        logic [`ADDR_W-1:0]                     addr;
        logic [`BYTE_W-1:0]                     rdata;
        logic [`NUM_CH-1:0][`BYTE_W-1:0]        enable;
        logic [`NUM_CH-1:0][`FLAG_W-1:0]        flag;
        logic [`NUM_CH-1:0][`FLAG_W-1:0]        armed;
        logic [`NUM_CH-1:0]                     trig;
    } core_state_type;

    // ======================================================================
    // channels 0 and 3 carry compare c/d, the others carry underflow
    function automatic logic has_cd(input logic [`CH_W-1:0] ch);
        return (ch == 3'h0) || (ch == 3'h3);
    endfunction : has_cd

    function automatic logic [`BYTE_W-1:0] writable_mask(input logic [`CH_W-1:0] ch);
        return has_cd(ch) ? `MASK_CD_CH : `MASK_UDF_CH;
    endfunction : writable_mask

endpackage : timer_irq_pkg

/* File: hdl/channel_irq_gate.sv */
`timescale 1ns/10ps
`include "timer_irq_defs.svh"

module channel_irq_gate (
    // channel enable register and status flags
    input  wire logic [`BYTE_W-1:0]              enable,
    input  wire logic [`FLAG_W-1:0]              flag,
    // gated requests
    output timer_irq_pkg::channel_request_type   request
);
    import timer_irq_pkg::*;

    // ======================================================================
    // level requests, no memory: dropping flag or enable drops the request
    always_comb begin
        request.underflow_irq_request = flag[`BIT_UDF] & enable[`BIT_UDF];
        request.overflow_irq_request  = flag[`BIT_OVF] & enable[`BIT_OVF];
        request.match_d_irq_request   = flag[`BIT_MD]  & enable[`BIT_MD];
        request.match_c_irq_request   = flag[`BIT_MC]  & enable[`BIT_MC];
        request.match_b_irq_request   = flag[`BIT_MB]  & enable[`BIT_MB];
        request.match_a_irq_request   = flag[`BIT_MA]  & enable[`BIT_MA];
    end

endmodule : channel_irq_gate

/* File: hdl/timer_channel_irq_enable.sv */
`timescale 1ns/10ps
`include "timer_irq_defs.svh"

// Overview of operation
// - six 8-bit enable registers, software read/write
// - bit 7 gates register-a conversion start
// - bit 6 reserved, reads 1, writes ignored
// - bit 5 gates underflow request, channels 1,2,4,5
// - bit 5 reserved zero in channels 0,3
// - bit 4 gates overflow request, every channel
// - bit 3 gates register-d request, channels 0,3
// - bit 3 reserved zero in channels 1,2,4,5
// - bit 2 gates register-c request, channels 0,3
// - bit 2 reserved zero in channels 1,2,4,5
// - bit 1 gates register-b request, every channel
// - bit 0 gates register-a request, every channel
// - underflow wrap sets flag in phase counting
// - overflow wrap sets the overflow flag
// - flag clears by writing 0 after reading 1

module timer_channel_irq_enable (
    // clock and reset
    input  wire logic                                   hclk,
    input  wire logic                                   hresetn,
    // ahb-lite slave
    input  wire logic                                   hsel,
    input  wire logic [31:0]                            haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic [31:0]                            hwdata,
    input  wire logic                                   hready,
    output logic                                        hreadyout,
    output logic [31:0]                                 hrdata,
    output logic                                        hresp,
    // counter and compare events, one-cycle pulses per channel
    input  wire timer_irq_pkg::channel_event_type [`NUM_CH-1:0] channel_events,
    input  wire logic [`NUM_CH-1:0]                     phase_count_mode,
    input  wire logic [`NUM_CH-1:0]                     count_up,
    // requests toward interrupt controller and converter
    output timer_irq_pkg::channel_request_type [`NUM_CH-1:0] irq_request,
    output logic [`NUM_CH-1:0]                          conversion_start_request
);
    import timer_irq_pkg::*;

    core_state_type state_reg;
    core_state_type state_next;

    // ======================================================================
    // address decode, used for both the data phase and the read path
    function automatic addr_decode_type decode_addr(input logic [`ADDR_W-1:0] a);
        addr_decode_type d;
        logic [`ADDR_W-1:0] off;
        d = '0;
        for (int i = 0; i < `NUM_CH; i++) begin
            off = `ADDR_W'(i) * `REG_STRIDE;
            if ((a & `WORD_ALIGN_MASK) != '0) begin
                d = d;
            end else if (a == (`EN_BASE + off)) begin
                d.hit_enable = 1'b1;
                d.ch         = `CH_W'(i);
            end else if (a == (`STAT_BASE + off)) begin
                d.hit_status = 1'b1;
                d.ch         = `CH_W'(i);
            end
        end
        return d;
    endfunction : decode_addr

    // status read-back: direction bit only exists where underflow exists
    function automatic logic [`BYTE_W-1:0] status_value(
        input logic [`CH_W-1:0]   ch,
        input logic [`FLAG_W-1:0] flg,
        input logic               up
    );
        logic top;
        top = has_cd(ch) ? 1'b1 : up;
        return {top, 1'b1, flg};
    endfunction : status_value

    // ======================================================================
    // next state
    always_comb begin
        addr_decode_type    wdec;
        addr_decode_type    rdec;
        logic [`BYTE_W-1:0] mask;
        logic [`FLAG_W-1:0] set;
        logic [`FLAG_W-1:0] clr;
        logic [`CH_W-1:0]   c;
        wdec       = '0;
        rdec       = '0;
        mask       = '0;
        set        = '0;
        clr        = '0;
        c          = '0;
        state_next = state_reg;

        // data phase of a write lands first, so a read right behind it sees it
        if (state_reg.phase == ST_WRITE) begin
            wdec = decode_addr(state_reg.addr);
            mask = writable_mask(wdec.ch);
            if (wdec.hit_enable) begin
                state_next.enable[wdec.ch] = (state_reg.enable[wdec.ch] & ~mask)
                                           | (hwdata[`BYTE_W-1:0] & mask);
            end else if (wdec.hit_status) begin
                clr = ~hwdata[`FLAG_W-1:0] & state_reg.armed[wdec.ch]
                    & mask[`FLAG_W-1:0];
                state_next.flag[wdec.ch]  = state_reg.flag[wdec.ch] & ~clr;
                state_next.armed[wdec.ch] = '0;
            end
        end

        // hardware events; a set in the clearing cycle wins
        for (int i = 0; i < `NUM_CH; i++) begin
            c    = `CH_W'(i);
            mask = writable_mask(c);
            set  = '0;
            set[`BIT_UDF] = channel_events[i].underflow & phase_count_mode[i];
            set[`BIT_OVF] = channel_events[i].overflow;
            set[`BIT_MD]  = channel_events[i].match[`MATCH_D_IDX];
            set[`BIT_MC]  = channel_events[i].match[`MATCH_C_IDX];
            set[`BIT_MB]  = channel_events[i].match[`MATCH_B_IDX];
            set[`BIT_MA]  = channel_events[i].match[`MATCH_A_IDX];
            state_next.flag[i] = state_next.flag[i] | (set & mask[`FLAG_W-1:0]);
            state_next.trig[i] = channel_events[i].match[`MATCH_A_IDX]
                               & state_reg.enable[i][`BIT_TRIG];
        end

        // address phase
        if (hsel && htrans[`HTRANS_NONSEQ_BIT] && hready) begin
            state_next.addr  = haddr[`ADDR_W-1:0];
            state_next.phase = hwrite ? ST_WRITE : ST_READ;
            state_next.rdata = '0;
            if (!hwrite) begin
                rdec = decode_addr(haddr[`ADDR_W-1:0]);
                if (rdec.hit_enable) begin
                    state_next.rdata = state_next.enable[rdec.ch] | `RSV_ONES;
                end else if (rdec.hit_status) begin
                    state_next.rdata = status_value(rdec.ch, state_next.flag[rdec.ch],
                                                    count_up[rdec.ch]);
                    // a flag seen as 1 by software may now be cleared
                    state_next.armed[rdec.ch] = state_next.armed[rdec.ch]
                                              | state_next.flag[rdec.ch];
                end
            end
        end else begin
            state_next.phase = ST_IDLE;
        end
    end

    // ======================================================================
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg.phase <= ST_IDLE;
            state_reg.addr  <= '0;
            state_reg.rdata <= '0;
            for (int i = 0; i < `NUM_CH; i++) begin
                state_reg.enable[i] <= `EN_RESET;
                state_reg.flag[i]   <= `FLAG_RESET;
                state_reg.armed[i]  <= `FLAG_RESET;
            end
            state_reg.trig  <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // bus answers: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = `HRESP_OKAY;
    assign hrdata    = {`RDATA_PAD, state_reg.rdata};

    // conversion start is a registered one-cycle pulse
    assign conversion_start_request = state_reg.trig;

    // ======================================================================
    // per-channel request gating
    generate
        for (genvar g = 0; g < `NUM_CH; g++) begin : g_channel
            channel_irq_gate u_gate (
                .enable  (state_reg.enable[g]),
                .flag    (state_reg.flag[g]),
                .request (irq_request[g])
            );
        end
    endgenerate

endmodule : timer_channel_irq_enable

/* File: tb/timer_irq_props.sv */
`timescale 1ns/10ps
`include "timer_irq_defs.svh"
// ==========
// port checker
module timer_irq_props
    import timer_irq_pkg::*;
(
    // clock and reset
    input wire logic                          hclk,
    input wire logic                          hresetn,
    // bus
    input wire logic                          hsel,
    input wire logic [31:0]                   haddr,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic                          hready,
    input wire logic [31:0]                   hrdata,
    // events and requests
    input wire channel_event_type [`NUM_CH-1:0]   channel_events,
    input wire channel_request_type [`NUM_CH-1:0] irq_request,
    input wire logic [`NUM_CH-1:0]            conversion_start_request
);
    logic       rd_dp;
    logic       wr_dp;
    logic [7:0] dp_addr;
    // data phase tracker, so reads are judged in the cycle hrdata stands
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp   <= 1'b0;
            wr_dp   <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            rd_dp   <= hsel && htrans[1] && hready && !hwrite;
            wr_dp   <= hsel && htrans[1] && hready && hwrite;
            dp_addr <= haddr[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_en_read;
        rd_dp && dp_addr < 8'h18 && dp_addr[1:0] == 2'h0;
    endsequence
    a_reserved_reads_one: assert property (s_en_read |-> hrdata[6] && hrdata[31:8] == 24'h0)
        else $error("reserved enable bit not read as one");
    a_cd_bits_zero: assert property (s_en_read ##0 (dp_addr inside {8'h04, 8'h08, 8'h10, 8'h14})
        |-> hrdata[3:2] == 2'h0) else $error("compare c/d enable bits not zero");
    a_udf_bit_zero: assert property (s_en_read ##0 (dp_addr inside {8'h00, 8'h0C})
        |-> !hrdata[5]) else $error("underflow enable bit not zero");
    a_reset_quiet: assert property ($rose(hresetn) |-> irq_request == '0
        && conversion_start_request == '0) else $error("request after reset");
    for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
        localparam bit CD = (i == 0) || (i == 3);
        a_trig_cause: assert property (conversion_start_request[i]
            |-> $past(channel_events[i].match[0])) else $error("trigger without event");
        a_absent_req: assert property (CD ? !irq_request[i].underflow_irq_request
            : !(irq_request[i].match_c_irq_request || irq_request[i].match_d_irq_request))
            else $error("request from absent source");
        a_match_rise: assert property ($rose(irq_request[i].match_a_irq_request)
            |-> $past(channel_events[i].match[0]) || $past(wr_dp)) else $error("bad rise");
        a_ovf_fall: assert property ($fell(irq_request[i].overflow_irq_request)
            |-> $past(wr_dp)) else $error("overflow request fell without write");
    end
endmodule : timer_irq_props

bind timer_channel_irq_enable timer_irq_props props_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .channel_events(channel_events), .irq_request(irq_request),
    .conversion_start_request(conversion_start_request));

/* File: tb/irq_sink.sv */
`timescale 1ns/10ps
`include "timer_irq_defs.svh"
// ==========
// interrupt controller and converter side: takes levels, counts start pulses
module irq_sink
    import timer_irq_pkg::*;
(
    input wire logic                          hclk,
    input wire logic                          hresetn,
    input wire channel_request_type [`NUM_CH-1:0] irq_request,
    input wire logic [`NUM_CH-1:0]            conversion_start_request,
    output int                                trig_count
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) trig_count <= 0;
        else trig_count <= trig_count + $countones(conversion_start_request);
    end
endmodule : irq_sink

/* File: tb/timer_channel_irq_enable_bench.sv */
`timescale 1ns/10ps
`include "timer_irq_defs.svh"
module timer_channel_irq_enable_bench;
    import timer_irq_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [5:0] pcm, cup, csr;
    channel_event_type [`NUM_CH-1:0] ev;
    channel_request_type [`NUM_CH-1:0] irq;
    int failures, tests_run, cyc, trig_count;
    timer_channel_irq_enable dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .channel_events(ev),
        .phase_count_mode(pcm), .count_up(cup), .irq_request(irq), .conversion_start_request(csr));
    irq_sink sink (.hclk(hclk), .hresetn(hresetn), .irq_request(irq),
        .conversion_start_request(csr), .trig_count(trig_count));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // ==========
    // shared tasks
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task pulse(input int ch, input logic [5:0] v);
        @(posedge hclk); ev[ch] <= v;
        @(posedge hclk); ev[ch] <= 6'h00;
        #1;
    endtask : pulse
    task req(input int ch, input logic [5:0] e);
        @(posedge hclk); #1;
        chk("irq_request", {26'h0, e}, {26'h0, irq[ch]});
    endtask : req
    // ==========
    // scenarios
    task t_regs;
        for (int c = 0; c < 6; c++) begin
            bus(0, 8'(4 * c), 0); chk("enable reset", 32'h40, r);
            bus(1, 8'(4 * c), 32'hFF); bus(0, 8'(4 * c), 0);
            chk("enable mask", (c == 0 || c == 3) ? 32'hDF : 32'hF3, r);
            bus(1, 8'(4 * c), 0);
        end
        bus(0, 8'h18, 0); chk("unmapped", 32'h0, r);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : t_regs
    task t_gate;
        logic [5:0] v;
        for (int c = 0; c < 6; c++) begin
            v = (c == 0 || c == 3) ? 6'h1F : 6'h33;
            pcm <= 6'h3F;
            pulse(c, 6'h3F); chk("masked", 0, {26'h0, irq[c]});
            bus(1, 8'(4 * c), 32'h15); req(c, 6'h15 & v);
            bus(1, 8'(4 * c), 32'h2A); req(c, 6'h2A & v);
            // a zero write without a prior read must not clear
            bus(1, 8'(8'h20 + 4 * c), 0); req(c, 6'h2A & v);
            bus(0, 8'(8'h20 + 4 * c), 0);
            chk("status flags", (c == 0 || c == 3) ? 32'hDF : 32'hF3, r);
            bus(1, 8'(8'h20 + 4 * c), 0); req(c, 0);
            bus(1, 8'(4 * c), 0);
        end
        pcm <= 6'h00;
        // event bit 4 is the underflow pulse; it must not set the flag outside phase counting
        bus(1, 8'h04, 32'h20); pulse(1, 6'h10); req(1, 0);
    endtask : t_gate
    task t_trig;
        bus(1, 8'h08, 32'h80); pulse(2, 6'h01); chk("trigger", 1, {31'h0, csr[2]});
        @(posedge hclk); #1 chk("trigger width", 0, {31'h0, csr[2]});
        bus(1, 8'h08, 0); pulse(2, 6'h01); chk("trigger off", 0, {31'h0, csr[2]});
        chk("trigger count", 1, 32'(trig_count));
    endtask : t_trig
    task t_clear;
        pulse(0, 6'h20); bus(1, 8'h00, 32'h10); req(0, 6'h10);
        bus(0, 8'h20, 0); chk("status overflow", 32'hD0, r);
        // writing ones after a read leaves the flag alone
        bus(1, 8'h20, 32'h3F); req(0, 6'h10);
        // overflow event lands in the clearing data phase: the set must win
        bus(0, 8'h20, 0);
        fork
            bus(1, 8'h20, 0);
            begin
                repeat (2) @(posedge hclk);
                ev[0] <= 6'h20;
                @(posedge hclk);
                ev[0] <= 6'h00;
            end
        join
        req(0, 6'h10);
        bus(0, 8'h20, 0); bus(1, 8'h20, 0); req(0, 6'h00);
        bus(1, 8'h00, 0);
    endtask : t_clear
    task results;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // hang guard, far beyond the few hundred cycles the run needs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            results;
        end
    end
    initial begin
        hresetn = 0; hsel = 0; htrans = 0; haddr = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
        ev = '0; pcm = 0; cup = 6'h3F; failures = 0; tests_run = 0; cyc = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_gate;
        t_trig;
        t_clear;
        results;
    end
endmodule : timer_channel_irq_enable_bench
